//--- rtl/sso_engine.sv
// string and store ordering engine: serialises core memory ops onto the bus
// assumes one request at a time on the bus port, answered by bus_done_in
//
// Summary of operation
// - locked ops issued singly, bus-serialised total order
// - loads wait behind earlier locked op
// - stores wait behind earlier locked op
// - loads issued in program order, except fast-move line reads (line 0, then top down)
// - fast moves loop line read, line invalidate; fast stores only invalidate
// - fast mode takes interrupts at line boundaries
// - invalidations may go in descending line order
// - enable bit 0 gates fast mode
// - fast mode only for ascending strings
// - fast mode needs count of 64 or more
// - refuse fast when overlap under one line
// - fast needs write-back or write-combining memory
// - fast may require 8-byte aligned indexes
// - out-of-order stores only with fast enabled
// - string stores complete before next string
// - string stores keep order with plain stores
// - interrupts precise, may wait to boundary
// - at handler entry index, count, pointer saved
// - resume continues from the stopped element
// - handler stores land between iterations k, k+1
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sso_engine
    import sso_pkg::*;
#(
    parameter int LINE_BYTES   = LINE_BYTES_NEW,
    parameter bit ALIGN_BOTH   = 1'b0,
    parameter bit ALIGN_CHECK  = 1'b1,
    parameter int ELEM_BYTES   = 4
) (
    input  wire logic              clk_sys_in,
    input  wire logic              arst_n_in,
    // instruction stream
    input  wire logic              op_valid_in,
    input  wire logic [2:0]        op_kind_in,
    input  wire logic [ADDR_W-1:0] op_addr_in,
    input  wire logic [ADDR_W-1:0] source_index_reg_in,
    input  wire logic [CNT_W-1:0]  op_count_in,
    input  wire logic              op_descending_in,
    input  wire logic [2:0]        src_mem_type_in,
    input  wire logic [2:0]        dst_mem_type_in,
    input  wire logic [ADDR_W-1:0] op_ip_in,
    output logic                   op_ready_out,
    // interrupt request from the core
    input  wire logic              irq_req_in,
    output logic                   irq_take_out,
    output logic [ADDR_W-1:0]      saved_instruction_pointer_out,
    output logic [ADDR_W-1:0]      saved_src_index_out,
    output logic [ADDR_W-1:0]      saved_dst_index_out,
    output logic [CNT_W-1:0]       saved_count_out,
    output logic                   fast_active_out,
    // external bus
    output logic                   bus_req_out,
    output logic [2:0]             bus_kind_out,
    output logic [ADDR_W-1:0]      bus_addr_out,
    input  wire logic              bus_done_in,
    // register port
    input  wire logic [3:0]        reg_addr_in,
    input  wire logic [31:0]       reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic [31:0]            reg_rdata_out
);
    localparam logic [3:0] REG_MISC_EN = 4'h0;
    localparam logic [3:0] REG_STATUS  = 4'h1;

    // elaboration checks on the parameters
    if (LINE_BYTES != LINE_BYTES_NEW && LINE_BYTES != LINE_BYTES_OLD) begin
        $error("line size must be 32 or 64");
    end
    if (ELEM_BYTES < 1 || ELEM_BYTES > LINE_BYTES || (LINE_BYTES % ELEM_BYTES) != 0) begin
        $error("element size out of range");
    end

    localparam logic [ADDR_W-1:0] LINE_B  = ADDR_W'(LINE_BYTES);
    localparam logic [ADDR_W-1:0] ELEM_B  = ADDR_W'(ELEM_BYTES);
    localparam logic [CNT_W-1:0]  PER_LN  = CNT_W'(LINE_BYTES / ELEM_BYTES);
    localparam logic [ADDR_W-1:0] AL_MASK = ADDR_W'(ALIGN_BYTES - 1);

    function automatic logic fast_type(input logic [2:0] mt);
        fast_type = (mt == MT_WRITE_BACK) || (mt == MT_WRITE_COMB);
    endfunction

    sso_state_t        state_ff, ret_ff;
    logic [31:0]       misc_en_ff;
    logic              fast_ff;
    logic              is_move_ff;
    logic              desc_ff;
    logic              lock_seen_ff;
    logic [ADDR_W-1:0] src_ff, dst_ff, ip_ff;
    logic [CNT_W-1:0]  cnt_ff;
    logic [CNT_W-1:0]  total_lines_ff;
    logic [CNT_W-1:0]  lines_done_ff;
    logic              bus_req_ff;
    logic [2:0]        bus_kind_ff;
    logic [ADDR_W-1:0] bus_addr_ff;
    logic              op_ready_ff;
    logic              irq_take_ff;
    logic [ADDR_W-1:0] sv_ip_ff, sv_src_ff, sv_dst_ff;
    logic [CNT_W-1:0]  sv_cnt_ff;
    logic [31:0]       rdata_ff;
    logic [31:0]       status_cnt_ff;

    // entry checks for fast mode
    wire logic              is_string  = op_kind_in == OP_STRING_MOVE
                                       || op_kind_in == OP_STRING_STORE;
    wire logic              is_move    = op_kind_in == OP_STRING_MOVE;
    wire logic              en_ok      = misc_en_ff[FAST_EN_BIT];
    wire logic              dir_ok     = !op_descending_in;
    wire logic              cnt_ok     = op_count_in >= CNT_W'(MIN_FAST_COUNT);
    wire logic [ADDR_W-1:0] gap_fwd    = op_addr_in - source_index_reg_in;
    wire logic [ADDR_W-1:0] gap_bwd    = source_index_reg_in - op_addr_in;
    wire logic              ovl_ok     = !is_move || (gap_fwd >= LINE_B
                                       && gap_bwd >= LINE_B);
    wire logic              type_ok    = fast_type(dst_mem_type_in)
                                       && (!is_move || fast_type(src_mem_type_in));
    wire logic              dst_al     = (op_addr_in & AL_MASK) == '0;
    wire logic              src_al     = !is_move
                                       || (source_index_reg_in & AL_MASK) == '0;
    wire logic              al_ok      = !ALIGN_CHECK
                                       || (dst_al && (!ALIGN_BOTH || src_al));
    wire logic              fast_go    = en_ok && dir_ok && cnt_ok && ovl_ok
                                       && type_ok && al_ok;
    wire logic [CNT_W-1:0]  n_lines    = (op_count_in + PER_LN - 1'b1) / PER_LN;
    wire logic              take_op    = op_valid_in && op_ready_ff;
    wire logic              at_idle    = state_ff == SSO_IDLE;
    wire logic [ADDR_W-1:0] step       = desc_ff ? -ELEM_B : ELEM_B;
    // line order: line 0 first, then from the last line downward, so stores
    // become visible out of sequential order inside one string
    wire logic [ADDR_W-1:0] ln_off     = (lines_done_ff == '0) ? '0
                                       : (total_lines_ff - lines_done_ff) * LINE_B;
    wire logic [ADDR_W-1:0] inv_addr   = dst_ff + ln_off;
    wire logic              last_line  = lines_done_ff + 1'b1 >= total_lines_ff;

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_ff       <= SSO_IDLE;
            ret_ff         <= SSO_IDLE;
            misc_en_ff     <= MISC_EN_RST[31:0];
            fast_ff        <= 1'b0;
            is_move_ff     <= 1'b0;
            desc_ff        <= 1'b0;
            lock_seen_ff   <= 1'b0;
            src_ff         <= '0;
            dst_ff         <= '0;
            ip_ff          <= '0;
            cnt_ff         <= '0;
            total_lines_ff <= '0;
            lines_done_ff  <= '0;
            bus_req_ff     <= 1'b0;
            bus_kind_ff    <= BK_NONE;
            bus_addr_ff    <= '0;
            op_ready_ff    <= 1'b0;
            irq_take_ff    <= 1'b0;
            sv_ip_ff       <= '0;
            sv_src_ff      <= '0;
            sv_dst_ff      <= '0;
            sv_cnt_ff      <= '0;
            rdata_ff       <= '0;
            status_cnt_ff  <= '0;
        end else begin
            irq_take_ff <= 1'b0;
            op_ready_ff <= 1'b0;
            if (reg_wr_in && reg_addr_in == REG_MISC_EN) begin
                misc_en_ff <= reg_wdata_in;
            end
            if (reg_rd_in && reg_addr_in == REG_MISC_EN) begin
                rdata_ff <= misc_en_ff;
            end else if (reg_rd_in && reg_addr_in == REG_STATUS) begin
                rdata_ff <= {status_cnt_ff[27:0], fast_ff, is_move_ff, lock_seen_ff,
                             !at_idle};
            end else begin
                rdata_ff <= '0;
            end
            case (state_ff)
                SSO_IDLE: begin
                    // one op in flight: every access, locked or not, is done
                    // before the next starts, so program order holds on the bus
                    op_ready_ff <= !op_ready_ff && !take_op;
                    if (take_op) begin
                        op_ready_ff <= 1'b0;
                        ip_ff       <= op_ip_in;
                        src_ff      <= source_index_reg_in;
                        dst_ff      <= op_addr_in;
                        cnt_ff      <= op_count_in;
                        is_move_ff  <= is_move;
                        desc_ff     <= op_descending_in;
                        if (is_string) begin
                            fast_ff        <= fast_go;
                            total_lines_ff <= n_lines;
                            lines_done_ff  <= '0;
                            if (op_count_in == '0) begin
                                state_ff <= SSO_IDLE;
                            end else if (fast_go) begin
                                state_ff <= is_move ? SSO_LINE_RD : SSO_LINE_INV;
                            end else begin
                                state_ff <= is_move ? SSO_ELEM_LD : SSO_ELEM_ST;
                            end
                        end else begin
                            fast_ff     <= 1'b0;
                            bus_req_ff  <= 1'b1;
                            bus_addr_ff <= op_addr_in;
                            ret_ff      <= SSO_IDLE;
                            state_ff    <= SSO_BUS_WAIT;
                            lock_seen_ff <= op_kind_in == OP_LOCKED_XCHG;
                            if (op_kind_in == OP_LOCKED_XCHG) begin
                                bus_kind_ff   <= BK_LOCKED;
                                status_cnt_ff <= status_cnt_ff + 1'b1;
                            end else if (op_kind_in == OP_LOAD) begin
                                bus_kind_ff <= BK_LOAD;
                            end else begin
                                bus_kind_ff <= BK_STORE;
                            end
                        end
                    end
                end
                SSO_ELEM_LD: begin
                    bus_req_ff  <= 1'b1;
                    bus_kind_ff <= BK_LOAD;
                    bus_addr_ff <= src_ff;
                    ret_ff      <= SSO_ELEM_ST;
                    state_ff    <= SSO_BUS_WAIT;
                end
                SSO_ELEM_ST: begin
                    bus_req_ff  <= 1'b1;
                    bus_kind_ff <= BK_STORE;
                    bus_addr_ff <= dst_ff;
                    ret_ff      <= SSO_DRAIN;
                    state_ff    <= SSO_BUS_WAIT;
                end
                SSO_LINE_RD: begin
                    bus_req_ff  <= 1'b1;
                    bus_kind_ff <= BK_LINE_READ;
                    bus_addr_ff <= src_ff + ln_off;
                    ret_ff      <= SSO_LINE_INV;
                    state_ff    <= SSO_BUS_WAIT;
                end
                SSO_LINE_INV: begin
                    bus_req_ff  <= 1'b1;
                    bus_kind_ff <= BK_LINE_INVAL;
                    bus_addr_ff <= inv_addr;
                    ret_ff      <= SSO_DRAIN;
                    state_ff    <= SSO_BUS_WAIT;
                end
                SSO_BUS_WAIT: begin
                    if (bus_done_in) begin
                        bus_req_ff  <= 1'b0;
                        bus_kind_ff <= BK_NONE;
                        state_ff    <= ret_ff;
                    end
                end
                SSO_DRAIN: begin
                    // one element or one line is complete; count, and in element mode the
                    // indexes, are stepped here to name the next unprocessed element
                    if (fast_ff) begin
                        lines_done_ff <= lines_done_ff + 1'b1;
                        cnt_ff <= (cnt_ff > PER_LN) ? cnt_ff - PER_LN : '0;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                        src_ff <= src_ff + step;
                        dst_ff <= dst_ff + step;
                    end
                    if ((fast_ff && last_line) || (!fast_ff && cnt_ff == 1)) begin
                        fast_ff  <= 1'b0;
                        state_ff <= SSO_IDLE;
                    end else if (irq_req_in) begin
                        // interrupt only here, between whole elements or lines
                        irq_take_ff <= 1'b1;
                        sv_ip_ff    <= ip_ff;
                        sv_cnt_ff   <= fast_ff ? cnt_ff - PER_LN : cnt_ff - 1'b1;
                        // lines go 0 then top down: line 1 is always the lowest left
                        sv_src_ff   <= fast_ff ? src_ff + LINE_B : src_ff + step;
                        sv_dst_ff   <= fast_ff ? dst_ff + LINE_B : dst_ff + step;
                        fast_ff     <= 1'b0;
                        state_ff    <= SSO_IDLE;
                    end else if (fast_ff) begin
                        state_ff <= is_move_ff ? SSO_LINE_RD : SSO_LINE_INV;
                    end else begin
                        state_ff <= is_move_ff ? SSO_ELEM_LD : SSO_ELEM_ST;
                    end
                end
                default: begin
                    state_ff <= SSO_IDLE;
                end
            endcase
        end
    end

    assign op_ready_out                  = op_ready_ff;
    assign irq_take_out                  = irq_take_ff;
    assign saved_instruction_pointer_out = sv_ip_ff;
    assign saved_src_index_out           = sv_src_ff;
    assign saved_dst_index_out           = sv_dst_ff;
    assign saved_count_out               = sv_cnt_ff;
    assign fast_active_out               = fast_ff;
    assign bus_req_out                   = bus_req_ff;
    assign bus_kind_out                  = bus_kind_ff;
    assign bus_addr_out                  = bus_addr_ff;
    assign reg_rdata_out                 = rdata_ff;
endmodule
`default_nettype wire

//--- rtl/sso_pkg.sv
// package for the string and store ordering engine
// assumes one core clock; addresses are byte addresses
package sso_pkg;
    localparam int          ADDR_W          = 32;
    localparam int          CNT_W           = 32;
    localparam int          LINE_BYTES_NEW  = 64;
    localparam int          LINE_BYTES_OLD  = 32;
    localparam int          MIN_FAST_COUNT  = 64;
    localparam int          ALIGN_BYTES     = 8;
    localparam int          FAST_EN_BIT     = 0;
    localparam logic [63:0] MISC_EN_RST     = 64'h0000_0000_0000_0001;
    // memory type codes
    localparam logic [2:0]  MT_UNCACHED     = 3'h0;
    localparam logic [2:0]  MT_WRITE_COMB   = 3'h1;
    localparam logic [2:0]  MT_WRITE_BACK   = 3'h6;
    // bus request kinds
    localparam logic [2:0]  BK_NONE         = 3'h0;
    localparam logic [2:0]  BK_LOAD         = 3'h1;
    localparam logic [2:0]  BK_STORE        = 3'h2;
    localparam logic [2:0]  BK_LOCKED       = 3'h3;
    localparam logic [2:0]  BK_LINE_READ    = 3'h4;
    localparam logic [2:0]  BK_LINE_INVAL   = 3'h5;
    // op kinds from the instruction stream
    localparam logic [2:0]  OP_LOAD         = 3'h0;
    localparam logic [2:0]  OP_STORE        = 3'h1;
    localparam logic [2:0]  OP_LOCKED_XCHG  = 3'h2;
    localparam logic [2:0]  OP_STRING_MOVE  = 3'h3;
    localparam logic [2:0]  OP_STRING_STORE = 3'h4;
    typedef enum logic [2:0] {
        SSO_IDLE,
        SSO_DRAIN,
        SSO_ELEM_LD,
        SSO_ELEM_ST,
        SSO_LINE_RD,
        SSO_LINE_INV,
        SSO_BUS_WAIT
    } sso_state_t;
endpackage

//--- sim/sso_bus_model.sv
// far side model: answers each bus request with one done pulse
// assumes one request at a time, held until done is seen
`timescale 1ns/1ps
`default_nettype none
module sso_bus_model (
    input  wire logic       clk_sys_in,
    input  wire logic       arst_n_in,
    input  wire logic       bus_req_in,
    input  wire logic [3:0] wait_in,
    output var logic        bus_done_out
);
    logic [3:0] cnt_ff;
    // one done per request, after wait_in idle cycles
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_ff       <= 4'h0;
            bus_done_out <= 1'b0;
        end else begin
            bus_done_out <= bus_req_in && !bus_done_out && cnt_ff >= wait_in;
            cnt_ff       <= (bus_req_in && !bus_done_out && cnt_ff < wait_in)
                            ? cnt_ff + 4'h1 : 4'h0;
        end
    end
endmodule
`default_nettype wire

//--- sim/sso_engine_props.sv
// checker for the string and store ordering engine
// assumes it is bound to sso_engine and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module sso_engine_props
    import sso_pkg::*;
(
    input wire logic              clk_sys_in,
    input wire logic              arst_n_in,
    input wire logic              op_valid_in,
    input wire logic [ADDR_W-1:0] op_addr_in,
    input wire logic [CNT_W-1:0]  op_count_in,
    input wire logic              op_descending_in,
    input wire logic [2:0]        src_mem_type_in,
    input wire logic [2:0]        dst_mem_type_in,
    input wire logic              op_ready_out,
    input wire logic              irq_req_in,
    input wire logic              irq_take_out,
    input wire logic              fast_active_out,
    input wire logic              bus_req_out,
    input wire logic [2:0]        bus_kind_out,
    input wire logic [ADDR_W-1:0] bus_addr_out,
    input wire logic              bus_done_in,
    input wire logic [3:0]        reg_addr_in,
    input wire logic [31:0]       reg_wdata_in,
    input wire logic              reg_wr_in,
    input wire logic              reg_rd_in,
    input wire logic [31:0]       reg_rdata_out
);
    logic en_ff, desc_ff, cnt_ok_ff, mt_ok_ff, al_ok_ff;
    wire  take_w  = op_valid_in && op_ready_out;
    wire  line_w  = bus_kind_out == BK_LINE_READ || bus_kind_out == BK_LINE_INVAL;
    wire  src_ok_w = src_mem_type_in == MT_WRITE_BACK || src_mem_type_in == MT_WRITE_COMB;
    wire  dst_ok_w = dst_mem_type_in == MT_WRITE_BACK || dst_mem_type_in == MT_WRITE_COMB;
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            en_ff     <= 1'b1;
            desc_ff   <= 1'b0;
            cnt_ok_ff <= 1'b0;
            mt_ok_ff  <= 1'b0;
            al_ok_ff  <= 1'b0;
        end else begin
            if (reg_wr_in && reg_addr_in == 4'h0) en_ff <= reg_wdata_in[FAST_EN_BIT];
            if (take_w) desc_ff <= op_descending_in;
            if (take_w) cnt_ok_ff <= op_count_in >= 32'h40;
            if (take_w) mt_ok_ff <= src_ok_w && dst_ok_w;
            if (take_w) al_ok_ff <= op_addr_in[2:0] == 3'h0;
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in);
    a_bus_req_holds: assert property (
        bus_req_out && !bus_done_in |=> bus_req_out && $stable(bus_kind_out) && $stable(bus_addr_out))
        else $error("bus request changed before done");
    a_req_drops_done: assert property (bus_req_out && bus_done_in |=> !bus_req_out)
        else $error("bus request held after done");
    a_fast_needs_en: assert property ($rose(fast_active_out) |-> en_ff)
        else $error("fast mode with enable clear");
    a_fast_ascending: assert property ($rose(fast_active_out) |-> !desc_ff)
        else $error("fast mode on descending string");
    a_fast_count_min: assert property ($rose(fast_active_out) |-> cnt_ok_ff)
        else $error("fast mode with short count");
    a_fast_mem_type: assert property ($rose(fast_active_out) |-> mt_ok_ff)
        else $error("fast mode on wrong memory type");
    a_fast_dst_align: assert property ($rose(fast_active_out) |-> al_ok_ff)
        else $error("fast mode on unaligned destination");
    a_fast_line_kinds: assert property (
        fast_active_out && $past(fast_active_out) && bus_req_out |-> line_w)
        else $error("element access in fast mode");
    a_line_needs_fast: assert property (
        bus_req_out && line_w |-> fast_active_out || $past(fast_active_out))
        else $error("line access outside fast mode");
    a_irq_at_boundary: assert property (irq_take_out |-> !bus_req_out && $past(irq_req_in))
        else $error("interrupt taken mid access");
    a_enable_readback: assert property (
        reg_rd_in && reg_addr_in == 4'h0 |=> reg_rdata_out == {31'h0, en_ff})
        else $error("enable register read back wrong");
endmodule
bind sso_engine sso_engine_props sso_engine_props_i (
    .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .op_valid_in(op_valid_in),
    .op_addr_in(op_addr_in), .op_count_in(op_count_in), .op_descending_in(op_descending_in),
    .src_mem_type_in(src_mem_type_in), .dst_mem_type_in(dst_mem_type_in),
    .op_ready_out(op_ready_out), .irq_req_in(irq_req_in), .irq_take_out(irq_take_out),
    .fast_active_out(fast_active_out), .bus_req_out(bus_req_out), .bus_kind_out(bus_kind_out),
    .bus_addr_out(bus_addr_out), .bus_done_in(bus_done_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out)
);
`default_nettype wire

//--- sim/sso_engine_tb.sv
// testbench for the string and store ordering engine
// assumes sso_bus_model on the bus side and the checker bound in
`timescale 1ns/1ps
`default_nettype none
module sso_engine_tb;
    import sso_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, desc = 1'b0, irq = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [2:0] kind = OP_LOAD, mt = MT_WRITE_BACK;
    logic [31:0] dst = 32'h0, src = 32'h0, cnt = 32'h0, wd = 32'h0, d;
    logic [3:0] ra = 4'h0, bus_wait = 4'h0;
    logic rdy, take, fast, breq, bdone, fast_seen;
    logic [2:0] bkind;
    logic [31:0] s_ip, s_src, s_dst, s_cnt, baddr, rdata;
    logic [34:0] log_q[$];
    int err_total = 0, num_checks = 0, takes = 0;
    initial forever #4 clk = ~clk;
    sso_engine sso_engine_i (.clk_sys_in(clk), .arst_n_in(rst_n), .op_valid_in(vld),
        .op_kind_in(kind), .op_addr_in(dst), .source_index_reg_in(src), .op_count_in(cnt),
        .op_descending_in(desc), .src_mem_type_in(mt), .dst_mem_type_in(mt),
        .op_ip_in(dst + 32'h1000), .op_ready_out(rdy), .irq_req_in(irq), .irq_take_out(take),
        .saved_instruction_pointer_out(s_ip), .saved_src_index_out(s_src),
        .saved_dst_index_out(s_dst), .saved_count_out(s_cnt), .fast_active_out(fast),
        .bus_req_out(breq), .bus_kind_out(bkind), .bus_addr_out(baddr), .bus_done_in(bdone),
        .reg_addr_in(ra), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata));
    sso_bus_model sso_bus_model_i (.clk_sys_in(clk), .arst_n_in(rst_n), .bus_req_in(breq),
        .wait_in(bus_wait), .bus_done_out(bdone));
    always @(posedge clk) begin
        if (breq === 1'b1 && bdone === 1'b1) log_q.push_back({bkind, baddr});
        if (fast === 1'b1) fast_seen = 1'b1;
        if (take === 1'b1) takes++;
    end
    task automatic check(input string what, input logic [34:0] seen, input logic [34:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out;
        if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        ra <= a; wd <= v; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        ra <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        v = rdata;
    endtask
    task automatic issue(input logic [2:0] k, input logic [31:0] da, sa, c, input logic ds);
        int n;
        n = 0;
        @(posedge clk);
        vld <= 1'b1; kind <= k; dst <= da; src <= sa; cnt <= c; desc <= ds;
        do @(posedge clk); while (rdy !== 1'b1 && ++n < 300);
        vld <= 1'b0;
        check("op accepted", n < 300, 1'b1);
    endtask
    task automatic settle;
        d = 32'h1;
        for (int n = 0; n < 3000 && d[0] !== 1'b0; n++) reg_read(4'h1, d);
        check("engine idle", d[0], 1'b0);
    endtask
    task automatic start(input logic [2:0] k, input logic [31:0] da, sa, c, input logic ds);
        log_q.delete();
        fast_seen = 1'b0;
        issue(k, da, sa, c, ds);
        settle();
    endtask
    initial begin
        #1 repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        reg_read(4'h0, d); check("misc enable", d, 32'h1);
        reg_read(4'hf, d); check("unmapped", d, 32'h0);
        log_q.delete();
        issue(OP_LOCKED_XCHG, 32'h100, 0, 0, 0);
        issue(OP_LOAD, 32'h200, 0, 0, 0);
        issue(OP_STORE, 32'h300, 0, 0, 0);
        settle();
        check("locked first", log_q[0], {BK_LOCKED, 32'h100});
        check("load after lock", log_q[1], {BK_LOAD, 32'h200});
        check("store after lock", log_q[2], {BK_STORE, 32'h300});
        reg_read(4'h1, d); check("lock count", d[31:4], 28'h1);
        start(OP_STRING_STORE, 32'h1000, 0, 64, 0);
        check("fast entered", fast_seen, 1'b1);
        check("line count", log_q.size(), 4);
        check("first line", log_q[0], {BK_LINE_INVAL, 32'h1000});
        check("top line", log_q[1], {BK_LINE_INVAL, 32'h10c0});
        check("last line", log_q[3], {BK_LINE_INVAL, 32'h1040});
        bus_wait <= 4'h3;
        start(OP_STRING_MOVE, 32'h2000, 32'h4000, 64, 0);
        check("move lines", log_q.size(), 8);
        check("move read", log_q[0][34:32], BK_LINE_READ);
        bus_wait <= 4'h0;
        for (int i = 0; i < 5; i++) begin
            mt <= (i == 2) ? MT_UNCACHED : MT_WRITE_BACK;
            if (i == 4) reg_write(4'h0, 32'h0);
            start(OP_STRING_STORE, (i == 3) ? 32'h3004 : 32'h3000, 0, (i == 1) ? 63 : 64, i == 0);
            check("no fast", fast_seen, 1'b0);
            check("elem count", log_q.size(), (i == 1) ? 63 : 64);
            check("elem order", log_q[1], {BK_STORE, dst + ((i == 0) ? -4 : 4)});
            check("elem last", log_q[log_q.size()-1][34:32], BK_STORE);
        end
        reg_write(4'h0, 32'h1);
        start(OP_STRING_MOVE, 32'h5020, 32'h5000, 64, 0);
        check("overlap load", log_q[0], {BK_LOAD, 32'h5000});
        check("overlap store", log_q[1], {BK_STORE, 32'h5020});
        irq <= 1'b1;
        bus_wait <= 4'h2;
        start(OP_STRING_STORE, 32'h6000, 0, 128, 0);
        irq <= 1'b0;
        check("irq taken", takes, 1);
        check("saved ip", s_ip, 32'h7000);
        check("saved src", s_src, 32'h40);
        check("saved dst", s_dst, 32'h6040);
        check("saved count", s_cnt, 112);
        check("done before irq", log_q.size(), 1);
        log_q.delete();
        issue(OP_STORE, 32'h9000, 0, 0, 0);
        issue(OP_STRING_STORE, s_dst, s_src, s_cnt, 0);
        issue(OP_STORE, 32'h9100, 0, 0, 0);
        settle();
        check("handler store", log_q[0], {BK_STORE, 32'h9000});
        check("resume line", log_q[1], {BK_LINE_INVAL, 32'h6040});
        check("resume size", log_q.size(), 9);
        check("plain after string", log_q[8], {BK_STORE, 32'h9100});
        close_out();
    end
    initial begin
        #400000;
        err_total++;
        close_out();
    end
endmodule
`default_nettype wire
